// *** inc/pmc_map.vh ***
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// command codes, which double as register offsets
`define PMC_CMD_PAGE 8'h00
`define PMC_CMD_OPERATION 8'h01
`define PMC_CMD_ONOFF_CFG 8'h02
`define PMC_CMD_CLEAR_FAULTS 8'h03
`define PMC_CMD_STORE_USER 8'h15
`define PMC_CMD_RESTORE_USER 8'h16
`define PMC_CMD_TEXT_ID 8'h99

// reset values
`define PMC_PAGE_RST 8'h00
`define PMC_OPERATION_RST 8'h00
`define PMC_ONOFF_RST 8'h17
`define PMC_SEC_RST 8'h00
`define PMC_SEC_AFTER_RESTORE 8'h01

// page codes
`define PMC_PAGE_P0 8'h00
`define PMC_PAGE_P1 8'h01
`define PMC_PAGE_BOTH 8'hFF

// output control encodings, bits 7:6 state and 5:4 margin
`define PMC_OP_STATE_HI 7
`define PMC_OP_STATE_LO 6
`define PMC_OP_MARGIN_HI 5
`define PMC_OP_MARGIN_LO 4
`define PMC_ST_IMM_OFF 2'b00
`define PMC_ST_SOFT_OFF 2'b01
`define PMC_ST_ON 2'b10
`define PMC_OP_IMM_OFF 8'h00
`define PMC_OP_SOFT_OFF 8'h40
`define PMC_OP_ON_NOM 8'h80
`define PMC_OP_ON_MLOW 8'h90
`define PMC_OP_ON_MHIGH 8'hA0

// start source configuration fields
`define PMC_CFG_SRC_HI 4
`define PMC_CFG_SRC_LO 2
`define PMC_CFG_POL_BIT 1
`define PMC_CFG_OFF_BIT 0
`define PMC_SRC_PIN_ONLY 3'b101
`define PMC_SRC_CMD_ONLY 3'b110

// fault status: bits 6:0 latch conditions until cleared, bit 7 is command error
`define PMC_FAULT_CML_BIT 7

// nonvolatile busy time
`define PMC_NVM_BUSY_MS 100
`define PMC_CORE_CLK_KHZ 20000
`define PMC_NVM_CNT_W 22
// 100 ms of 20 MHz core clock, already sized to the busy counter
`define PMC_NVM_BUSY_CYCLES 22'h1E_8480

`endif

// *** hdl/pmc_sync.v ***
`default_nettype none

// two flop synchroniser, per bit
module pmc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;

  // the first stage feeds only the second stage
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      // reset to the idle level of each pin, so no false edge follows reset
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // pmc_sync

`default_nettype wire

// *** hdl/pmc_phase_ctrl.v ***
`default_nettype none
`include "pmc_map.vh"

// per phase output control byte, start source configuration and on/off decision
module pmc_phase_ctrl (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_op_we,
  input wire i_cfg_we,
  input wire [7:0] i_wdata,
  input wire i_load,
  input wire [7:0] i_load_cfg,
  input wire i_enable_pin,
  output reg [7:0] o_op_state,
  output reg [7:0] o_cfg,
  output reg o_on,
  output reg o_off_immediate,
  output reg [1:0] o_margin
);

  reg [7:0] op_q;
  reg want_on;
  reg off_imm_sel;
  wire [1:0] op_st = op_q[`PMC_OP_STATE_HI:`PMC_OP_STATE_LO];
  wire [2:0] src = o_cfg[`PMC_CFG_SRC_HI:`PMC_CFG_SRC_LO];
  wire cmd_on = (op_st == `PMC_ST_ON);

  // start source and turn-off style; a command off wins over the pin off style
  always @* begin
    want_on = i_enable_pin & cmd_on;
    off_imm_sel = o_cfg[`PMC_CFG_OFF_BIT];
    case (src)
      `PMC_SRC_PIN_ONLY: begin
        want_on = i_enable_pin;
      end
      `PMC_SRC_CMD_ONLY: begin
        want_on = cmd_on;
        off_imm_sel = (op_st == `PMC_ST_IMM_OFF);
      end
      default: begin
        if (!cmd_on) begin
          off_imm_sel = (op_st == `PMC_ST_IMM_OFF);
        end
      end
    endcase
  end

  // stored bytes; the output control byte never comes from the user store
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      op_q <= `PMC_OPERATION_RST;
      o_cfg <= `PMC_ONOFF_RST;
    end else begin
      if (i_op_we) begin
        op_q <= i_wdata;
      end
      if (i_load) begin
        o_cfg <= i_load_cfg;
      end else if (i_cfg_we) begin
        // unused bits read zero, polarity bit is fixed high
        o_cfg <= {3'b000, i_wdata[4:2], 1'b1, i_wdata[0]};
      end
    end
  end

  // present state, also what a read of the control byte returns
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_on <= 1'b0;
      o_off_immediate <= 1'b1;
      o_margin <= 2'b00;
      o_op_state <= `PMC_OPERATION_RST;
    end else begin
      o_on <= want_on;
      o_off_immediate <= ~want_on & off_imm_sel;
      o_margin <= want_on ? op_q[`PMC_OP_MARGIN_HI:`PMC_OP_MARGIN_LO] : 2'b00;
      if (want_on) begin
        o_op_state <= {`PMC_ST_ON, op_q[5:4], 4'h0};
      end else if (off_imm_sel) begin
        o_op_state <= {`PMC_ST_IMM_OFF, 6'h00};
      end else begin
        o_op_state <= {`PMC_ST_SOFT_OFF, 6'h00};
      end
    end
  end

endmodule // pmc_phase_ctrl

`default_nettype wire

// *** hdl/pmc_top.v ***
`default_nettype none
`include "pmc_map.vh"

// How it works
// - page byte picks phase one, two, or both
// - page register byte wide, unprotected, resets zero
// - control byte: state bits 7:6, margin 5:4
// - immediate off skips delay and fall ramp
// - control byte reads live state, never stored
// - undefined control byte encodings flag command error
// - control byte paged, protectable, resets immediate off
// - config bits 4:2 pick pin or command start
// - enable pin is active high only
// - config bit 0 picks immediate or soft off for pin turn-off
// - config byte paged, protectable, resets 0x17
// - clear faults, unless write-protected, wipes status and releases alert
// - standing faults set again at once
// - clearing faults never restarts an output
// - store copies settings, bus ignored 100 ms
// - restore loads settings, also at power-up
// - restore completion sets security level one
// - bus ignored while restoring; host waits
// - block transfers lead with a byte count
// - text commands return ASCII strings
module pmc_top #(
  parameter [6:0] P_DEV_ADDR = 7'h40,
  parameter [`PMC_NVM_CNT_W-1:0] P_NVM_BUSY_CYCLES = `PMC_NVM_BUSY_CYCLES,
  parameter P_TEXT_LEN = 4,
  parameter [8*P_TEXT_LEN-1:0] P_TEXT = 32'h504D_4331
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_smb_clk,
  input wire i_smb_dat,
  output reg o_smb_dat,
  output reg o_smb_dat_oe_n,
  output reg o_alert_out_oe_n,
  input wire i_enable,
  input wire i_write_protect,
  input wire [6:0] i_fault_cond,
  output reg [7:0] o_fault_status,
  output reg [7:0] o_security_level,
  output reg o_nvm_busy,
  output wire [1:0] o_phase_on,
  output wire [1:0] o_phase_off_immediate,
  output wire [3:0] o_phase_margin
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RX = 3'd1;
  localparam [2:0] ST_RX_ACK = 3'd2;
  localparam [2:0] ST_TX = 3'd3;
  localparam [2:0] ST_TX_ACK = 3'd4;
  localparam [7:0] LP_TEXT_LEN = P_TEXT_LEN[7:0];

  wire scl_s;
  wire sda_s;
  wire en_s;
  reg scl_q;
  reg sda_q;
  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg is_addr_q;
  reg rd_mode_q;
  reg tx_ack_q;
  reg [7:0] cmd_q;
  reg [3:0] nbytes_q;
  reg [3:0] rd_idx_q;
  reg [7:0] page_q;
  reg [7:0] wdata_q;
  reg op_we_q;
  reg cfg_we_q;
  reg clr_q;
  reg store_q;
  reg restore_cmd_q;
  reg cml_set_q;
  reg [`PMC_NVM_CNT_W-1:0] busy_cnt_q;
  reg restoring_q;
  reg load_q;
  reg [7:0] usr_page_q;
  reg [7:0] usr_cfg0_q;
  reg [7:0] usr_cfg1_q;
  reg [7:0] rd_byte;
  wire [7:0] fault_d;
  wire [7:0] op_state0;
  wire [7:0] op_state1;
  wire [7:0] cfg0;
  wire [7:0] cfg1;
  wire [8*P_TEXT_LEN-1:0] text_sh;

  // bus pins and the enable pin cross into the core clock here
  pmc_sync #(
    .WIDTH(3),
    .RST_VAL(3'b110)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_async({i_smb_clk, i_smb_dat, i_enable}),
    .o_sync({scl_s, sda_s, en_s})
  );

  // edges and bus conditions seen on the synchronised lines
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

  // page selection decode
  wire sel_p0 = (page_q == `PMC_PAGE_P0) | (page_q == `PMC_PAGE_BOTH);
  wire sel_p1 = (page_q == `PMC_PAGE_P1) | (page_q == `PMC_PAGE_BOTH);
  wire rd_p1 = (page_q == `PMC_PAGE_P1);
  wire page_ok = (sh_q == `PMC_PAGE_P0) | (sh_q == `PMC_PAGE_P1) | (sh_q == `PMC_PAGE_BOTH);
  wire op_ok = (sh_q == `PMC_OP_IMM_OFF) | (sh_q == `PMC_OP_SOFT_OFF) |
               (sh_q == `PMC_OP_ON_NOM) | (sh_q == `PMC_OP_ON_MLOW) | (sh_q == `PMC_OP_ON_MHIGH);

  assign text_sh = P_TEXT >> (8 * (P_TEXT_LEN - rd_idx_q));

  // read data for the current command and byte index
  always @* begin
    rd_byte = 8'hFF;
    case (cmd_q)
      `PMC_CMD_PAGE: begin
        rd_byte = page_q;
      end
      `PMC_CMD_OPERATION: begin
        rd_byte = rd_p1 ? op_state1 : op_state0;
      end
      `PMC_CMD_ONOFF_CFG: begin
        rd_byte = rd_p1 ? cfg1 : cfg0;
      end
      `PMC_CMD_TEXT_ID: begin
        if (rd_idx_q == 4'h0) begin
          rd_byte = LP_TEXT_LEN;
        end else if (rd_idx_q <= LP_TEXT_LEN[3:0]) begin
          rd_byte = text_sh[7:0];
        end else begin
          rd_byte = 8'h00;
        end
      end
      default: begin
        rd_byte = 8'hFF;
      end
    endcase
  end

  // bus byte engine and command decode; ignores every start while busy
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      is_addr_q <= 1'b0;
      rd_mode_q <= 1'b0;
      tx_ack_q <= 1'b0;
      cmd_q <= 8'h00;
      nbytes_q <= 4'h0;
      rd_idx_q <= 4'h0;
      page_q <= `PMC_PAGE_RST;
      wdata_q <= 8'h00;
      op_we_q <= 1'b0;
      cfg_we_q <= 1'b0;
      clr_q <= 1'b0;
      store_q <= 1'b0;
      restore_cmd_q <= 1'b0;
      cml_set_q <= 1'b0;
      o_smb_dat <= 1'b0;
      o_smb_dat_oe_n <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      op_we_q <= 1'b0;
      cfg_we_q <= 1'b0;
      clr_q <= 1'b0;
      store_q <= 1'b0;
      restore_cmd_q <= 1'b0;
      cml_set_q <= 1'b0;
      if (bus_stop) begin
        st_q <= ST_IDLE;
        o_smb_dat_oe_n <= 1'b1;
        rd_mode_q <= 1'b0;
        // forget the count, or a later foreign frame's stop replays the command
        nbytes_q <= 4'h0;
        // data-less commands act on the stop that ends them
        if (!rd_mode_q && nbytes_q == 4'h1 && !o_nvm_busy) begin
          case (cmd_q)
            `PMC_CMD_CLEAR_FAULTS: begin
              clr_q <= ~i_write_protect;
              cml_set_q <= i_write_protect;
            end
            `PMC_CMD_STORE_USER: begin
              store_q <= 1'b1;
            end
            `PMC_CMD_RESTORE_USER: begin
              restore_cmd_q <= 1'b1;
            end
            default: begin
              cml_set_q <= 1'b1;
            end
          endcase
        end
      end else if (bus_start) begin
        st_q <= o_nvm_busy ? ST_IDLE : ST_RX;
        cnt_q <= 4'h0;
        is_addr_q <= 1'b1;
        o_smb_dat_oe_n <= 1'b1;
      end else begin
        case (st_q)
          ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              is_addr_q <= 1'b0;
              if (is_addr_q) begin
                if (sh_q[7:1] == P_DEV_ADDR) begin
                  o_smb_dat_oe_n <= 1'b0;
                  st_q <= ST_RX_ACK;
                  rd_mode_q <= sh_q[0];
                  rd_idx_q <= 4'h0;
                  if (!sh_q[0]) begin
                    nbytes_q <= 4'h0;
                  end
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                o_smb_dat_oe_n <= 1'b0;
                st_q <= ST_RX_ACK;
                if (nbytes_q != 4'hF) begin
                  nbytes_q <= nbytes_q + 4'h1;
                end
                if (nbytes_q == 4'h0) begin
                  cmd_q <= sh_q;
                end else if (nbytes_q == 4'h1) begin
                  wdata_q <= sh_q;
                  case (cmd_q)
                    `PMC_CMD_PAGE: begin
                      if (page_ok) begin
                        page_q <= sh_q;
                      end else begin
                        cml_set_q <= 1'b1;
                      end
                    end
                    `PMC_CMD_OPERATION: begin
                      op_we_q <= op_ok & ~i_write_protect;
                      cml_set_q <= ~op_ok | i_write_protect;
                    end
                    `PMC_CMD_ONOFF_CFG: begin
                      cfg_we_q <= ~i_write_protect;
                      cml_set_q <= i_write_protect;
                    end
                    default: begin
                      cml_set_q <= 1'b1;
                    end
                  endcase
                end
              end
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rd_mode_q) begin
                sh_q <= rd_byte;
                o_smb_dat_oe_n <= rd_byte[7];
                rd_idx_q <= rd_idx_q + 4'h1;
                st_q <= ST_TX;
              end else begin
                o_smb_dat_oe_n <= 1'b1;
                st_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == 4'h7) begin
                o_smb_dat_oe_n <= 1'b1;
                st_q <= ST_TX_ACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                o_smb_dat_oe_n <= sh_q[6];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              tx_ack_q <= ~sda_s;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (tx_ack_q) begin
                sh_q <= rd_byte;
                o_smb_dat_oe_n <= rd_byte[7];
                rd_idx_q <= rd_idx_q + 4'h1;
                st_q <= ST_TX;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
      if (load_q) begin
        page_q <= usr_page_q;
      end
    end
  end

  // user store and busy timer; the power-up restore starts straight from reset
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_nvm_busy <= 1'b1;
      busy_cnt_q <= {`PMC_NVM_CNT_W{1'b0}};
      restoring_q <= 1'b1;
      load_q <= 1'b0;
      o_security_level <= `PMC_SEC_RST;
      usr_page_q <= `PMC_PAGE_RST;
      usr_cfg0_q <= `PMC_ONOFF_RST;
      usr_cfg1_q <= `PMC_ONOFF_RST;
    end else begin
      load_q <= 1'b0;
      if (o_nvm_busy) begin
        if (busy_cnt_q >= P_NVM_BUSY_CYCLES - 1'b1) begin
          o_nvm_busy <= 1'b0;
          load_q <= restoring_q;
          if (restoring_q) begin
            o_security_level <= `PMC_SEC_AFTER_RESTORE;
          end
        end else begin
          busy_cnt_q <= busy_cnt_q + 1'b1;
        end
      end else if (store_q) begin
        // the output control byte is deliberately left out of the store
        usr_page_q <= page_q;
        usr_cfg0_q <= cfg0;
        usr_cfg1_q <= cfg1;
        o_nvm_busy <= 1'b1;
        busy_cnt_q <= {`PMC_NVM_CNT_W{1'b0}};
        restoring_q <= 1'b0;
      end else if (restore_cmd_q) begin
        o_nvm_busy <= 1'b1;
        busy_cnt_q <= {`PMC_NVM_CNT_W{1'b0}};
        restoring_q <= 1'b1;
      end
    end
  end

  // a condition still present in the clear cycle sets its bit again
  assign fault_d = (o_fault_status & ~{8{clr_q}}) | {cml_set_q, i_fault_cond};

  // fault status and alert; clearing touches no phase state
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_fault_status <= 8'h00;
      o_alert_out_oe_n <= 1'b1;
    end else begin
      o_fault_status <= fault_d;
      o_alert_out_oe_n <= ~(|fault_d);
    end
  end

  // page code 0x00 addresses the first phase, held in index 0
  pmc_phase_ctrl u_phase0 (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_op_we(op_we_q & sel_p0),
    .i_cfg_we(cfg_we_q & sel_p0),
    .i_wdata(wdata_q),
    .i_load(load_q),
    .i_load_cfg(usr_cfg0_q),
    .i_enable_pin(en_s),
    .o_op_state(op_state0),
    .o_cfg(cfg0),
    .o_on(o_phase_on[0]),
    .o_off_immediate(o_phase_off_immediate[0]),
    .o_margin(o_phase_margin[1:0])
  );

  pmc_phase_ctrl u_phase1 (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_op_we(op_we_q & sel_p1),
    .i_cfg_we(cfg_we_q & sel_p1),
    .i_wdata(wdata_q),
    .i_load(load_q),
    .i_load_cfg(usr_cfg1_q),
    .i_enable_pin(en_s),
    .o_op_state(op_state1),
    .o_cfg(cfg1),
    .o_on(o_phase_on[1]),
    .o_off_immediate(o_phase_off_immediate[1]),
    .o_margin(o_phase_margin[3:2])
  );

endmodule // pmc_top

`default_nettype wire

// *** verification/pmc_top_monitor.sv ***
`default_nettype none
// watches the block's pins only; all checks run on the core clock
module pmc_top_monitor #(
  parameter logic [21:0] P_NVM_BUSY_CYCLES = 22'h3E8
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_smb_clk,
  input wire logic [6:0] i_fault_cond,
  input wire logic o_smb_dat_oe_n,
  input wire logic o_alert_out_oe_n,
  input wire logic [7:0] o_fault_status,
  input wire logic [7:0] o_security_level,
  input wire logic o_nvm_busy,
  input wire logic [1:0] o_phase_on,
  input wire logic [1:0] o_phase_off_immediate,
  input wire logic [3:0] o_phase_margin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [21:0] busy_cnt_q;
  // length of the running busy window; too long for a repetition operator
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      busy_cnt_q <= 22'h0;
    end else begin
      busy_cnt_q <= o_nvm_busy ? busy_cnt_q + 22'h1 : 22'h0;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_reset_outputs: assert property ($fell(i_reset) |->
    o_nvm_busy && o_security_level == 8'h00 && o_fault_status == 8'h00)
    else $error("outputs wrong after reset");
  a_busy_window: assert property ($fell(o_nvm_busy) |->
    busy_cnt_q >= P_NVM_BUSY_CYCLES - 22'h2 && busy_cnt_q <= P_NVM_BUSY_CYCLES + 22'h2)
    else $error("busy window has wrong length");
  a_bus_quiet: assert property (o_nvm_busy |-> o_smb_dat_oe_n)
    else $error("data driven while busy");
  a_level_one: assert property ($fell(o_nvm_busy) |-> ##[0:2] o_security_level == 8'h01)
    else $error("security level not one");
  a_alert_tracks: assert property (o_alert_out_oe_n == (o_fault_status == 8'h00))
    else $error("alert does not follow status");
  a_fault_sets: assert property (i_fault_cond != 7'h00 |=>
    (o_fault_status[6:0] & $past(i_fault_cond)) == $past(i_fault_cond))
    else $error("standing fault not flagged");
  a_clear_at_stop: assert property (!$past(i_reset) &&
    ($past(o_fault_status) & ~o_fault_status) != 8'h00 |-> i_smb_clk && $past(i_smb_clk, 4))
    else $error("status cleared outside a stop");
  a_on_not_imm: assert property ((o_phase_on & o_phase_off_immediate) == 2'b00)
    else $error("phase both on and off");
  a_margin_off: assert property (!o_phase_on[0] |-> o_phase_margin[1:0] == 2'b00)
    else $error("margin while off");
endmodule // pmc_top_monitor

bind pmc_top pmc_top_monitor #(.P_NVM_BUSY_CYCLES(P_NVM_BUSY_CYCLES)) pmc_top_monitor_i (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_smb_clk(i_smb_clk),
  .i_fault_cond(i_fault_cond), .o_smb_dat_oe_n(o_smb_dat_oe_n),
  .o_alert_out_oe_n(o_alert_out_oe_n), .o_fault_status(o_fault_status),
  .o_security_level(o_security_level), .o_nvm_busy(o_nvm_busy), .o_phase_on(o_phase_on),
  .o_phase_off_immediate(o_phase_off_immediate), .o_phase_margin(o_phase_margin)
);
`default_nettype wire

// *** verification/pmc_host_model.sv ***
`default_nettype none
// bus host: owns the clock, only ever pulls data low
module pmc_host_model #(
  parameter logic [6:0] P_ADDR = 7'h40
) (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] r;
  logic a;
  // idle bus: clock stands high, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // data moves only while clock is low; one bit takes 300 ns
  task automatic bit_io(input logic b, output logic s);
    #100 o_sda_low = !b;
    #100 o_scl = 1'b1;
    #100 s = i_sda;
    o_scl = 1'b0;
  endtask
  // msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ack);
    ack = !ack;
  endtask
  task automatic start;
    #100 o_sda_low = 1'b0;
    #100 o_scl = 1'b1;
    #100 o_sda_low = 1'b1;
    #100 o_scl = 1'b0;
  endtask
  // stop, then a quiet gap before the next frame
  task automatic stop;
    #100 o_sda_low = 1'b1;
    #100 o_scl = 1'b1;
    #100 o_sda_low = 1'b0;
    #1000;
  endtask
  // write byte or send byte; ok reports the address acknowledge
  task automatic wr(input logic [7:0] c, input logic has_d, input logic [7:0] d,
                    output logic ok);
    start;
    xfer({P_ADDR, 1'b0}, 1'b1, r, ok);
    if (ok) begin
      xfer(c, 1'b1, r, a);
      if (has_d) xfer(d, 1'b1, r, a);
    end
    stop;
  endtask
  // read n bytes after a repeated start, nack on the last
  task automatic rd(input logic [7:0] c, input int n, output logic [7:0] q [6]);
    start;
    xfer({P_ADDR, 1'b0}, 1'b1, r, a);
    xfer(c, 1'b1, r, a);
    start;
    xfer({P_ADDR, 1'b1}, 1'b1, r, a);
    for (int i = 0; i < n; i++) xfer(8'hFF, i == n - 1, q[i], a);
    stop;
  endtask
endmodule // pmc_host_model
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [21:0] NVM_CYC = 22'h3E8;
  localparam logic [31:0] TXT = "PMC1";
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic wp = 1'b0;
  logic [6:0] cond = 7'h00;
  logic scl, sda_low, sda, sda_oe_n, sda_dat, alert_n, busy, ok;
  logic [7:0] fst, sec;
  logic [7:0] rb [6];
  logic [1:0] on, offi;
  logic [3:0] mg;
  logic [7:0] ops [5] = '{8'h00, 8'h40, 8'h80, 8'h90, 8'hA0};
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // open-drain data wire with pull-up
  assign sda = !sda_low && (sda_oe_n || sda_dat);
  pmc_top #(.P_NVM_BUSY_CYCLES(NVM_CYC), .P_TEXT(TXT)) pmc_top_i (
    .i_core_clk(clk), .i_reset(rst), .i_smb_clk(scl), .i_smb_dat(sda), .o_smb_dat(sda_dat),
    .o_smb_dat_oe_n(sda_oe_n), .o_alert_out_oe_n(alert_n), .i_enable(en),
    .i_write_protect(wp), .i_fault_cond(cond), .o_fault_status(fst),
    .o_security_level(sec), .o_nvm_busy(busy), .o_phase_on(on),
    .o_phase_off_immediate(offi), .o_phase_margin(mg)
  );
  pmc_host_model pmc_host_model_i (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string w);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic put(input logic [7:0] c, input logic [7:0] d);
    pmc_host_model_i.wr(c, 1'b1, d, ok);
    check(ok, 1'b1, "address ack");
    wait_cyc(4);
  endtask
  task automatic send(input logic [7:0] c);
    pmc_host_model_i.wr(c, 1'b0, 8'h00, ok);
    check(ok, 1'b1, "address ack");
    wait_cyc(4);
  endtask
  task automatic get(input logic [7:0] c, input logic [7:0] e, input string w);
    pmc_host_model_i.rd(c, 1, rb);
    check(rb[0], e, w);
  endtask
  // bounded wait for the storage window to close
  task automatic idle;
    for (int i = 0; i < 1200 && busy !== 1'b0; i++) @(negedge clk);
    check(busy, 1'b0, "busy end");
  endtask
  task automatic t_reset;
    check(busy, 1'b1, "power-up restore");
    pmc_host_model_i.wr(8'h00, 1'b1, 8'h01, ok);
    check(ok, 1'b0, "bus ignored");
    idle;
    wait_cyc(2);
    check(sec, 8'h01, "security");
    get(8'h00, 8'h00, "page reset");
    get(8'h01, 8'h00, "control reset");
    get(8'h02, 8'h17, "config reset");
    check({on, offi}, 4'b0011, "off at reset");
    pmc_host_model_i.rd(8'h99, 5, rb);
    check(rb[0], 8'h04, "text length");
    for (int i = 1; i < 5; i++) check(rb[i], TXT[39 - 8 * i -: 8], "text");
    $display("test reset done");
  endtask
  task automatic t_pin;
    en = 1'b1;
    wait_cyc(6);
    check(on, 2'b11, "pin start");
    put(8'h02, 8'hF4);
    get(8'h02, 8'h16, "config fixed bits");
    en = 1'b0;
    wait_cyc(6);
    check(on, 2'b00, "pin stop");
    check(offi, 2'b10, "soft and immediate off");
    $display("test pin done");
  endtask
  // outputs stay off throughout: storage is never used while operating
  // power-up restore, then the config write of the pin test, then store
  task automatic t_nvm;
    send(8'h15);
    check(busy, 1'b1, "store busy");
    pmc_host_model_i.wr(8'h02, 1'b1, 8'h1B, ok);
    check(ok, 1'b0, "ignored while storing");
    idle;
    get(8'h02, 8'h16, "write dropped");
    put(8'h02, 8'h17);
    send(8'h16);
    idle;
    get(8'h02, 8'h16, "restored config");
    $display("test store done");
  endtask
  task automatic t_op;
    put(8'h00, 8'hFF);
    put(8'h02, 8'h1B);
    for (int i = 0; i < 5; i++) begin
      put(8'h01, ops[i]);
      check(on, ops[i][7] ? 2'b11 : 2'b00, "on state");
      check(offi, ops[i] == 8'h00 ? 2'b11 : 2'b00, "off style");
      check(mg, {2{ops[i][5:4]}}, "margin");
      get(8'h01, ops[i], "control readback");
    end
    put(8'h00, 8'h01);
    put(8'h01, 8'h00);
    check(on, 2'b01, "second page only");
    put(8'h00, 8'h00);
    get(8'h01, 8'hA0, "first page kept");
    put(8'h01, 8'hC0);
    check(fst[7], 1'b1, "bad encoding");
    $display("test control done");
  endtask
  task automatic t_fault;
    wp = 1'b1;
    put(8'h01, 8'h00);
    check(on, 2'b01, "protected write");
    wp = 1'b0;
    cond = 7'h05;
    wait_cyc(3);
    check(fst, 8'h85, "faults latched");
    check(alert_n, 1'b0, "alert on");
    cond = 7'h01;
    send(8'h03);
    check(fst, 8'h01, "standing fault");
    check(on, 2'b01, "no restart");
    cond = 7'h00;
    send(8'h03);
    check(fst, 8'h00, "cleared");
    check(alert_n, 1'b1, "alert released");
    // source 000 needs both the pin and the command byte
    put(8'h02, 8'h03);
    check(on, 2'b00, "pin and command, pin low");
    en = 1'b1;
    wait_cyc(6);
    check(on, 2'b01, "pin and command, pin high");
    $display("test faults done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    wait_cyc(4);
    rst = 1'b0;
    t_reset;
    t_pin;
    t_nvm;
    t_op;
    t_fault;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
